// >>> design/psefe_pkg.sv
// Package for the start/limit and supply event register bank
package psefe_pkg;
    // Command codes
    localparam logic [7:0] CMD_START_LIMIT_VIEW = 8'h08;
    localparam logic [7:0] CMD_START_LIMIT_CLEAR = 8'h09;
    localparam logic [7:0] CMD_SUPPLY_FAULT_VIEW = 8'h0a;
    localparam logic [7:0] CMD_SUPPLY_FAULT_CLEAR = 8'h0b;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // Field layout and reset values
    localparam int NUM_CH = 4;
    localparam int NUM_PORT = 2;
    localparam int STARTUP_LSB = 0;
    localparam int CURRENT_LIMIT_LSB = 4;
    localparam logic [7:0] START_LIMIT_RESET = 8'h00;
    localparam logic [7:0] SUPPLY_FAULT_RESET = 8'h70;
    localparam logic [3:0] CH_CLEAR = 4'h0;

    // Cool-down timing
    localparam int CLK_KHZ = 25000;
    localparam int COOLDOWN_MS = 1000;
    localparam int COOLDOWN_CYCLES = COOLDOWN_MS * CLK_KHZ;
    localparam int COOL_CNT_W = 25;
    localparam logic [COOL_CNT_W-1:0] COOL_ZERO = 25'h0;
    localparam logic [COOL_CNT_W-1:0] COOL_ONE = 25'h1;

    // Channel sequencing states
    typedef enum logic [2:0] {
        CH_OFF,
        CH_WAIT,
        CH_INRUSH,
        CH_PARKED,
        CH_ON,
        CH_COOL
    } psefe_chan_state_t;

    // Per-channel inputs from the port control logic
    typedef struct packed {
        logic [3:0] channel_power_on_cmd;
        logic [3:0] channel_power_off_cmd;
        logic [3:0] start_allowed;
        logic [3:0] inrush_end;
        logic [3:0] inrush_bad;
        logic [3:0] limit_timeout;
        logic [3:0] discovery_error;
    } psefe_chan_in_t;

    // Port wiring, classification and auto mode
    typedef struct packed {
        logic [1:0] four_pair;
        logic [1:0] dual_sig;
        logic [1:0] class_7_8;
        logic auto_mode;
    } psefe_port_cfg_t;

    // Per-channel status outputs
    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] power_good_flag;
        logic [3:0] cooling;
        logic [3:0] power_enable_change;
        logic [3:0] cause_update;
    } psefe_chan_out_t;
endpackage

// >>> design/psefe_event_regs.sv
// Start/limit and supply event registers with four-pair inrush sequencing
`timescale 1ns/10ps
module psefe_event_regs #(
    parameter logic [psefe_pkg::COOL_CNT_W-1:0] COOLDOWN_CYCLES =
        psefe_pkg::COOL_CNT_W'(psefe_pkg::COOLDOWN_CYCLES)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command read port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    output logic rd_valid_q,
    output logic [7:0] rd_data_q,
    // Channel events and configuration
    input wire psefe_pkg::psefe_chan_in_t chan_in,
    input wire psefe_pkg::psefe_port_cfg_t port_cfg,
    input wire logic [7:0] supply_event,
    // Channel status
    output psefe_pkg::psefe_chan_out_t chan_out,
    // Summary toward the interrupt register
    output logic start_limit_pending,
    output logic supply_fault_pending
);

    // Sequencer state and cool-down counters
    psefe_pkg::psefe_chan_state_t st_q [psefe_pkg::NUM_CH];
    psefe_pkg::psefe_chan_state_t st_d [psefe_pkg::NUM_CH];
    logic [psefe_pkg::COOL_CNT_W-1:0] cool_q [psefe_pkg::NUM_CH];

    // Inrush outcome and event set terms
    logic [3:0] fault_kill;
    logic [3:0] good_end;
    logic [3:0] startup_fault_set;
    logic [3:0] current_limit_fault_set;
    logic [3:0] ch_off;

    // Channel flags
    logic [3:0] enable_q;
    logic [3:0] enable_d;
    logic [3:0] power_good_flag_q;
    logic [3:0] power_enable_change_q;
    logic [3:0] cause_q;

    // Event registers
    logic [3:0] startup_fault_q;
    logic [3:0] current_limit_fault_q;
    logic [7:0] supply_q;

    // Clearing read strobes
    logic clr_start_limit;
    logic clr_supply;

    // Inrush end decode per channel
    assign fault_kill = {4{1'b1}} & chan_in.inrush_end & chan_in.inrush_bad;
    assign good_end = chan_in.inrush_end & ~chan_in.inrush_bad;
    assign ch_off = chan_in.channel_power_off_cmd;

    // Clearing reads decode
    assign clr_start_limit = cmd_valid && (cmd_code == psefe_pkg::CMD_START_LIMIT_CLEAR);
    assign clr_supply = cmd_valid && (cmd_code == psefe_pkg::CMD_SUPPLY_FAULT_CLEAR);

    // Per-channel sequencer
    genvar c;
    generate
        for (c = 0; c < psefe_pkg::NUM_CH; c = c + 1) begin : g_ch
            // Partner channel, port index and role
            localparam int P = c ^ 1;
            localparam int PORT = c / 2;
            localparam bit PRIMARY = (c % 2) == 0;

            logic ss;
            logic par;
            logic ser;
            logic kill_me;
            logic kill_pt;
            logic start;
            logic cool_done;

            // Port style for this channel
            assign ss = port_cfg.four_pair[PORT] & ~port_cfg.dual_sig[PORT];
            assign par = ss & port_cfg.class_7_8[PORT];
            assign ser = ss & ~port_cfg.class_7_8[PORT];
            assign kill_me = (st_q[c] == psefe_pkg::CH_INRUSH) && fault_kill[c];
            assign kill_pt = ss && (st_q[P] == psefe_pkg::CH_INRUSH) && fault_kill[P];
            assign start = (chan_in.channel_power_on_cmd[c] | (ss & chan_in.channel_power_on_cmd[P]))
                & chan_in.start_allowed[c];
            assign cool_done = cool_q[c] >= COOLDOWN_CYCLES - psefe_pkg::COOL_ONE;

            // Next state
            always_comb begin
                st_d[c] = st_q[c];
                if (ch_off[c] || (ss && ch_off[P])) begin
                    st_d[c] = psefe_pkg::CH_OFF;
                end else begin
                    case (st_q[c])
                        psefe_pkg::CH_OFF: begin
                            if (start) begin
                                if (ser && !PRIMARY) begin
                                    st_d[c] = psefe_pkg::CH_WAIT;
                                end else begin
                                    st_d[c] = psefe_pkg::CH_INRUSH;
                                end
                            end
                        end
                        psefe_pkg::CH_WAIT: begin
                            if (kill_pt) begin
                                st_d[c] = psefe_pkg::CH_COOL;
                            end else if (st_q[P] == psefe_pkg::CH_INRUSH && good_end[P]) begin
                                st_d[c] = psefe_pkg::CH_ON;
                            end
                        end
                        psefe_pkg::CH_INRUSH: begin
                            if (kill_me || kill_pt) begin
                                st_d[c] = psefe_pkg::CH_COOL;
                            end else if (good_end[c]) begin
                                if (!par || st_q[P] == psefe_pkg::CH_PARKED
                                    || (st_q[P] == psefe_pkg::CH_INRUSH && good_end[P])) begin
                                    st_d[c] = psefe_pkg::CH_ON;
                                end else begin
                                    st_d[c] = psefe_pkg::CH_PARKED;
                                end
                            end
                        end
                        psefe_pkg::CH_PARKED: begin
                            if (kill_pt) begin
                                st_d[c] = psefe_pkg::CH_COOL;
                            end else if (st_q[P] == psefe_pkg::CH_INRUSH && good_end[P]) begin
                                st_d[c] = psefe_pkg::CH_ON;
                            end
                        end
                        psefe_pkg::CH_ON: begin
                            if (chan_in.limit_timeout[c] || (ss && chan_in.limit_timeout[P])) begin
                                st_d[c] = psefe_pkg::CH_OFF;
                            end
                        end
                        psefe_pkg::CH_COOL: begin
                            if (cool_done) begin
                                st_d[c] = psefe_pkg::CH_OFF;
                            end
                        end
                        default: begin
                            st_d[c] = psefe_pkg::CH_OFF;
                        end
                    endcase
                end
            end

            // State register
            always_ff @(posedge clk) begin
                if (reset) begin
                    st_q[c] <= psefe_pkg::CH_OFF;
                end else begin
                    st_q[c] <= st_d[c];
                end
            end

            // One-second cool-down counter
            always_ff @(posedge clk) begin
                if (reset) begin
                    cool_q[c] <= psefe_pkg::COOL_ZERO;
                end else if (st_q[c] == psefe_pkg::CH_COOL) begin
                    cool_q[c] <= cool_q[c] + psefe_pkg::COOL_ONE;
                end else begin
                    cool_q[c] <= psefe_pkg::COOL_ZERO;
                end
            end

            // Event set terms
            assign startup_fault_set[c] = kill_me || kill_pt
                || (chan_in.discovery_error[c] && !port_cfg.auto_mode);
            assign current_limit_fault_set[c] = (st_q[c] == psefe_pkg::CH_ON)
                && chan_in.limit_timeout[c];
            assign enable_d[c] = (st_d[c] == psefe_pkg::CH_INRUSH) || (st_d[c] == psefe_pkg::CH_PARKED)
                || (st_d[c] == psefe_pkg::CH_ON); // Parked channel stays powered
        end
    endgenerate

    // Start fault bits, sticky, set wins over clear
    always_ff @(posedge clk) begin
        if (reset) begin
            startup_fault_q <= psefe_pkg::START_LIMIT_RESET[psefe_pkg::STARTUP_LSB +: 4];
        end else begin
            startup_fault_q <= (startup_fault_q & ~(ch_off | {4{clr_start_limit}}))
                | startup_fault_set;
        end
    end

    // Current-limit fault bits, sticky, set wins over clear
    always_ff @(posedge clk) begin
        if (reset) begin
            current_limit_fault_q <= psefe_pkg::START_LIMIT_RESET[psefe_pkg::CURRENT_LIMIT_LSB +: 4];
        end else begin
            current_limit_fault_q <= (current_limit_fault_q & ~(ch_off | {4{clr_start_limit}}))
                | current_limit_fault_set;
        end
    end

    // Supply and fault events
    always_ff @(posedge clk) begin
        if (reset) begin
            supply_q <= psefe_pkg::SUPPLY_FAULT_RESET;
        end else begin
            supply_q <= (supply_q & ~{8{clr_supply}}) | supply_event;
        end
    end

    // Channel enable follows the next state
    always_ff @(posedge clk) begin
        if (reset) begin
            enable_q <= psefe_pkg::CH_CLEAR;
        end else begin
            enable_q <= enable_d;
        end
    end

    // Power good once a channel is fully on
    always_ff @(posedge clk) begin
        if (reset) begin
            power_good_flag_q <= psefe_pkg::CH_CLEAR;
        end else begin
            for (int i = 0; i < psefe_pkg::NUM_CH; i++) begin
                power_good_flag_q[i] <= st_d[i] == psefe_pkg::CH_ON;
            end
        end
    end

    // One-cycle pulse on each enable change
    always_ff @(posedge clk) begin
        if (reset) begin
            power_enable_change_q <= psefe_pkg::CH_CLEAR;
        end else begin
            power_enable_change_q <= enable_q ^ enable_d;
        end
    end

    // Strobe to the power-on cause register
    always_ff @(posedge clk) begin
        if (reset) begin
            cause_q <= psefe_pkg::CH_CLEAR;
        end else begin
            cause_q <= chan_in.discovery_error & {4{~port_cfg.auto_mode}};
        end
    end

    // Command read answer, one cycle after the command
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= psefe_pkg::UNMAPPED_DATA;
        end else begin
            rd_valid_q <= cmd_valid;
            if (!cmd_valid) begin
                rd_data_q <= rd_data_q;
            end else if (cmd_code == psefe_pkg::CMD_START_LIMIT_VIEW
                || cmd_code == psefe_pkg::CMD_START_LIMIT_CLEAR) begin
                rd_data_q <= {current_limit_fault_q, startup_fault_q};
            end else if (cmd_code == psefe_pkg::CMD_SUPPLY_FAULT_VIEW
                || cmd_code == psefe_pkg::CMD_SUPPLY_FAULT_CLEAR) begin
                rd_data_q <= supply_q;
            end else begin
                rd_data_q <= psefe_pkg::UNMAPPED_DATA;
            end
        end
    end

    // Outputs from the flag registers and the state decode
    always_comb begin
        chan_out.enable = enable_q;
        chan_out.power_good_flag = power_good_flag_q;
        chan_out.power_enable_change = power_enable_change_q;
        chan_out.cause_update = cause_q;
        chan_out.cooling = psefe_pkg::CH_CLEAR;
        for (int i = 0; i < psefe_pkg::NUM_CH; i++) begin
            chan_out.cooling[i] = st_q[i] == psefe_pkg::CH_COOL;
        end
    end
    assign start_limit_pending = |{current_limit_fault_q, startup_fault_q};
    assign supply_fault_pending = |supply_q;

endmodule

// >>> verif/psefe_event_regs_chk.sv
// Concurrent checks on the event register bank ports
`timescale 1ns/10ps
module psefe_event_regs_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command read port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic rd_valid_q,
    input wire logic [7:0] rd_data_q,
    // Channel and supply side
    input wire psefe_pkg::psefe_chan_in_t chan_in,
    input wire logic [7:0] supply_event,
    input wire psefe_pkg::psefe_chan_out_t chan_out,
    // Summary toward the interrupt register
    input wire logic start_limit_pending,
    input wire logic supply_fault_pending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Read answer timing and mapping
    property p_answer; cmd_valid |=> rd_valid_q; endproperty
    property p_no_extra; !cmd_valid |=> !rd_valid_q; endproperty
    property p_unmapped; cmd_valid && !(cmd_code inside {[8'h08:8'h0b]}) |=> rd_data_q == 8'h00; endproperty
    property p_view_match;
        rd_valid_q && $past(cmd_code) == psefe_pkg::CMD_START_LIMIT_VIEW |->
            (rd_data_q != 8'h00) == $past(start_limit_pending);
    endproperty
    // Clearing reads release the summary when nothing new arrives
    property p_clear_release;
        cmd_valid && cmd_code == psefe_pkg::CMD_START_LIMIT_CLEAR && chan_in.limit_timeout == 4'h0 &&
            (chan_in.inrush_end & chan_in.inrush_bad) == 4'h0 && chan_in.discovery_error == 4'h0
            |=> !start_limit_pending;
    endproperty
    property p_supply_clear;
        cmd_valid && cmd_code == psefe_pkg::CMD_SUPPLY_FAULT_CLEAR && supply_event == 8'h00
            |=> !supply_fault_pending;
    endproperty
    // Channel events and status
    property p_limit_set; (chan_in.limit_timeout & chan_out.power_good_flag) != 4'h0 |=> start_limit_pending; endproperty
    property p_enable_change; chan_out.power_enable_change == (chan_out.enable ^ $past(chan_out.enable)); endproperty
    property p_fault_cool;
        (chan_in.inrush_end & chan_in.inrush_bad & chan_out.enable & ~chan_out.power_good_flag) != 4'h0
            |=> (chan_out.cooling != 4'h0)[*8];
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    a_no_extra: assert property (p_no_extra) else $error("answer without read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped code not zero");
    a_view_match: assert property (p_view_match) else $error("read data and pending disagree");
    a_clear_release: assert property (p_clear_release) else $error("clearing read kept pending");
    a_supply_clear: assert property (p_supply_clear) else $error("supply clear kept pending");
    a_limit_set: assert property (p_limit_set) else $error("limit timeout not latched");
    a_enable_change: assert property (p_enable_change) else $error("enable change flag wrong");
    a_fault_cool: assert property (p_fault_cool) else $error("inrush fault without cool-down");
    // Main scenarios reached
    c_clear: cover property (cmd_valid && cmd_code == psefe_pkg::CMD_START_LIMIT_CLEAR);
    c_cool: cover property (chan_out.cooling == 4'h3);
    c_pg_pair: cover property (chan_out.power_good_flag == 4'h3);
endmodule
bind psefe_event_regs psefe_event_regs_chk u_chk (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .chan_in(chan_in),
    .supply_event(supply_event), .chan_out(chan_out), .start_limit_pending(start_limit_pending),
    .supply_fault_pending(supply_fault_pending));

// >>> verif/psefe_host_model.sv
// Host model issuing command reads to the event register bank
`timescale 1ns/10ps
module psefe_host_model (
    // Clock
    input wire logic clk,
    // Command read port toward the device
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    input wire logic rd_valid_q,
    input wire logic [7:0] rd_data_q
);
    // Idle between reads
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
    end
    // One read: strobe for one edge, answer taken once that edge lands
    task automatic host_read(input logic [7:0] code, output logic [7:0] data);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        #1;
        data = rd_valid_q ? rd_data_q : 8'hxx;
    endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the event register bank
`timescale 1ns/10ps
module tb_top;
    localparam logic [3:0] Z = 4'h0;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic rd_valid_q;
    logic [7:0] rd_data_q;
    logic [7:0] supply_event = 8'h00;
    logic start_limit_pending;
    logic supply_fault_pending;
    psefe_pkg::psefe_chan_in_t ci = 28'h00f0000;
    psefe_pkg::psefe_port_cfg_t cfg = 7'h00;
    psefe_pkg::psefe_chan_out_t co;
    int mismatches = 0;
    int samples_checked = 0;
    // Free-running clock
    always #20 clk = ~clk;
    // Device with a short cool-down
    psefe_event_regs #(.COOLDOWN_CYCLES(25'h14)) DUT (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .chan_in(ci), .port_cfg(cfg),
        .supply_event(supply_event), .chan_out(co), .start_limit_pending(start_limit_pending),
        .supply_fault_pending(supply_fault_pending));
    // Host issuing command reads
    psefe_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rd_valid_q(rd_valid_q),
        .rd_data_q(rd_data_q));
    // Compare and count
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        logic [7:0] d;
        host.host_read(code, d);
        check($sformatf("read %h", code), exp, d);
    endtask
    // One-cycle channel event, start always allowed
    task automatic drv(input logic [3:0] on, ie, bad, lt, de, off);
        @(posedge clk);
        ci <= '{on, off, 4'hf, ie, bad, lt, de};
        @(posedge clk);
        ci <= 28'h00f0000;
        #1;
    endtask
    task automatic en(input logic [3:0] e, input logic [3:0] g);
        check("enable", {4'h0, e}, {4'h0, co.enable});
        check("power good", {4'h0, g}, {4'h0, co.power_good_flag});
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
    // Test sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rd(8'h08, 8'h00);
        rd(8'h0a, 8'h70);
        rd(8'h0b, 8'h70);
        rd(8'h0a, 8'h00);
        rd(8'h3c, 8'h00);
        @(posedge clk) supply_event <= 8'h81;
        @(posedge clk) supply_event <= 8'h00;
        rd(8'h0a, 8'h81);
        rd(8'h0b, 8'h81);
        rd(8'h0a, 8'h00);
        $display("test reset and supply done");
        for (int i = 0; i < 4; i++) begin
            drv(4'h1 << i, Z, Z, Z, Z, Z);
            drv(Z, 4'h1 << i, Z, Z, Z, Z);
            en(4'h1 << i, 4'h1 << i);
            drv(Z, Z, Z, 4'h1 << i, Z, Z);
            en(Z, Z);
            rd(8'h08, 8'h10 << i);
            rd(8'h09, 8'h10 << i);
            drv(4'h1 << i, Z, Z, Z, Z, Z);
            drv(Z, 4'h1 << i, 4'h1 << i, Z, Z, Z);
            check("cooling", {4'h0, 4'h1 << i}, {4'h0, co.cooling});
            repeat (25) @(posedge clk);
            check("cooling end", 8'h00, {4'h0, co.cooling});
            rd(8'h09, 8'h01 << i);
            rd(8'h08, 8'h00);
        end
        $display("test two-pair channels done");
        @(posedge clk) cfg <= 7'h20;
        drv(4'h2, Z, Z, Z, Z, Z);
        en(4'h1, Z);
        drv(Z, 4'h1, Z, Z, Z, Z);
        en(4'h3, 4'h3);
        check("enable change", 8'h02, {4'h0, co.power_enable_change});
        drv(Z, Z, Z, 4'h2, Z, Z);
        en(Z, Z);
        rd(8'h09, 8'h20);
        drv(4'h1, Z, Z, Z, Z, Z);
        drv(Z, 4'h1, 4'h1, Z, Z, Z);
        en(Z, Z);
        check("cooling", 8'h03, {4'h0, co.cooling});
        repeat (25) @(posedge clk);
        rd(8'h09, 8'h03);
        $display("test serial single signature done");
        @(posedge clk) cfg <= 7'h22;
        drv(4'h1, Z, Z, Z, Z, Z);
        en(4'h3, Z);
        drv(Z, 4'h3, Z, Z, Z, Z);
        en(4'h3, 4'h3);
        drv(Z, Z, Z, Z, Z, 4'h3);
        drv(4'h1, Z, Z, Z, Z, Z);
        drv(Z, 4'h3, 4'h2, Z, Z, Z);
        en(Z, Z);
        check("cooling", 8'h03, {4'h0, co.cooling});
        repeat (25) @(posedge clk);
        rd(8'h09, 8'h03);
        $display("test parallel single signature done");
        @(posedge clk) cfg <= 7'h28;
        drv(4'h3, Z, Z, Z, Z, Z);
        drv(Z, 4'h2, 4'h2, Z, Z, Z);
        en(4'h1, Z);
        rd(8'h09, 8'h02);
        repeat (25) @(posedge clk);
        drv(4'h2, Z, Z, Z, Z, Z);
        en(4'h3, Z);
        $display("test dual signature done");
        @(posedge clk) cfg <= 7'h01;
        drv(Z, Z, Z, Z, 4'h4, Z);
        check("cause update", 8'h00, {4'h0, co.cause_update});
        rd(8'h09, 8'h00);
        @(posedge clk) cfg <= 7'h00;
        drv(Z, Z, Z, Z, 4'h4, Z);
        check("cause update", 8'h04, {4'h0, co.cause_update});
        rd(8'h08, 8'h04);
        drv(Z, Z, Z, Z, Z, 4'h4);
        rd(8'h08, 8'h00);
        fork
            rd(8'h09, 8'h00);
            drv(Z, Z, Z, Z, 4'h8, Z);
        join
        rd(8'h08, 8'h08);
        $display("test discovery and clearing done");
        print_verdict();
    end
endmodule
